// ===== hdl/ijc_exec.sv
// ijc_exec: executes increment, jump and call instructions of a 16-bit core.
// assumes: decode and effective address come from outside with exec_start;
// memory answers a read one cycle after the read strobe, never waits.
// register port writes are taken only while the sequencer is idle.
//
// Summary of operation
// - memory increment 72/62 reads byte, adds one, writes back there
// - memory and accumulator increments set N, Z, V; carry kept
// - overflow set exactly when operand was 7F before increment
// - N copies result msb; Z set only when result is 00
// - opcode 42 adds one to accumulator A with 8-bit flags
// - opcode 52 adds one to accumulator B with 8-bit flags
// - bytes 1B 81 add 0001 to the stack pointer
// - stack pointer increment leaves every flag unchanged
// - opcode 08 adds one to X, changes only Z from 16-bit result
// - opcode 02 adds one to Y, changes only Z from 16-bit result
// - jump 06/05 loads program counter with effective address
// - call return address is the next instruction's address
// - call subtracts 2 from stack, high byte at sp, low at sp+1
// - after call the stack pointer points at stored high byte
// - call 17/16/15 loads program counter with effective address
// - stacked return address is poppable by a later return
`timescale 1ns/1ps

module ijc_exec
   import ijc_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        exec_start_in,
   input  wire logic [7:0]  opcode_in,
   input  wire logic [7:0]  postbyte_in,
   input  wire logic [15:0] eff_addr_in,
   input  wire logic [15:0] next_pc_in,
   output logic             exec_done_out,
   output logic             illegal_out,
   output logic             busy_out,
   output logic [15:0]      mem_addr_out,
   output logic [7:0]       mem_wdata_out,
   output logic             mem_rd_out,
   output logic             mem_wr_out,
   input  wire logic [7:0]  mem_rdata_in,
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic [15:0]      reg_rdata_out
);

   // ==========================================================
   // types and state
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_MEM_READ,
      ST_MEM_WRITE,
      ST_PUSH_LO,
      ST_FINISH
   } ijc_state_type;

   // what a taken opcode asks of the sequencer and the buses
   typedef enum logic [2:0] {
      CL_MEM_INC,
      CL_CALL,
      CL_SINGLE,
      CL_STACK,
      CL_UNKNOWN
   } ijc_class_type;

   ijc_state_type state;
   logic [7:0]    acc_a;
   logic [7:0]    acc_b;
   logic [15:0]   index_x;
   logic [15:0]   index_y;
   logic [15:0]   stack_pointer;
   logic [15:0]   prog_counter;
   logic [7:0]    condition_flags;
   logic [15:0]   ret_addr;
   logic [15:0]   stack_dec;
   logic [11:0]   inc8_mem;
   logic [11:0]   inc8_a;
   logic [11:0]   inc8_b;
   logic [15:0]   next_x;
   logic [15:0]   next_y;
   logic          take;
   ijc_class_type take_class;
   logic [15:0]   next_sp;

   // ==========================================================
   // 8-bit increment: {n, z, v, pad, sum}
   function automatic logic [11:0] inc8(input logic [7:0] opnd);
      logic [7:0] sum;
      sum  = opnd + BYTE_ONE;
      inc8 = {sum[7], (sum == BYTE_ZERO), (opnd == BYTE_MAXPOS),
              1'b0, sum};
   endfunction

   function automatic logic [7:0] put_nzv(input logic [7:0] flg,
                                          input logic [11:0] res);
      logic [7:0] f;
      f         = flg;
      f[FLAG_N] = res[11];
      f[FLAG_Z] = res[10];
      f[FLAG_V] = res[9];
      put_nzv   = f;
   endfunction

   function automatic logic [7:0] put_z16(input logic [7:0] flg,
                                          input logic [15:0] res);
      logic [7:0] f;
      f         = flg;
      f[FLAG_Z] = (res == WORD_ZERO);
      put_z16   = f;
   endfunction

   // ==========================================================
   // opcode classes, decoded once; used by every process but the two register ones
   function automatic ijc_class_type op_class(input logic [7:0] op);
      case (op)
         OP_INC_EXT, OP_INC_IDX: begin
            op_class = CL_MEM_INC;
         end
         OP_CALL_DIR, OP_CALL_EXT, OP_CALL_IDX: begin
            op_class = CL_CALL;
         end
         OP_INC_A, OP_INC_B, OP_INC_X, OP_INC_Y, OP_JMP_EXT,
         OP_JMP_IDX: begin
            op_class = CL_SINGLE;
         end
         OP_LEA_STACK: begin
            op_class = CL_STACK;
         end
         // unknown opcodes still finish in one cycle, flagged illegal
         default: begin
            op_class = CL_UNKNOWN;
         end
      endcase
   endfunction

   assign take      = exec_start_in && (state == ST_IDLE);
   assign inc8_mem  = inc8(mem_rdata_in);
   assign inc8_a    = inc8(acc_a);
   assign inc8_b    = inc8(acc_b);
   assign next_x    = index_x + WORD_ONE;
   assign next_y    = index_y + WORD_ONE;
   assign stack_dec = stack_pointer - WORD_TWO;
   assign next_sp   = stack_pointer + WORD_ONE;
   assign take_class = op_class(opcode_in);

   // ==========================================================
   // sequencer
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (take) begin
                  case (take_class)
                     CL_MEM_INC: state <= ST_MEM_READ;
                     CL_CALL:    state <= ST_PUSH_LO;
                     default:    state <= ST_IDLE;
                  endcase
               end
            end
            ST_MEM_READ:  state <= ST_MEM_WRITE;
            ST_MEM_WRITE: state <= ST_FINISH;
            ST_PUSH_LO:   state <= ST_FINISH;
            ST_FINISH:    state <= ST_IDLE;
            default:      state <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // completion and illegal pulses
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         exec_done_out <= 1'b0;
         illegal_out   <= 1'b0;
      end else begin
         exec_done_out <= 1'b0;
         illegal_out   <= 1'b0;
         if (state == ST_FINISH) begin
            exec_done_out <= 1'b1;
         end else if (take) begin
            case (take_class)
               CL_SINGLE: begin
                  exec_done_out <= 1'b1;
               end
               CL_STACK: begin
                  exec_done_out <= 1'b1;
                  // other stack postbytes belong to another unit
                  illegal_out   <= (postbyte_in != PB_STACK_P1);
               end
               CL_UNKNOWN: begin
                  exec_done_out <= 1'b1;
                  illegal_out   <= 1'b1;
               end
               default: ;
            endcase
         end
      end
   end

   // ==========================================================
   // busy level, from the taken start up to the done pulse
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         busy_out <= 1'b0;
      end else if (take) begin
         busy_out <= (take_class == CL_MEM_INC) || (take_class == CL_CALL);
      end else begin
         // drops as the finish state ends, so done and idle coincide
         busy_out <= (state == ST_MEM_READ) || (state == ST_MEM_WRITE) ||
                     (state == ST_PUSH_LO);
      end
   end

   // ==========================================================
   // memory bus master
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         mem_addr_out  <= RST_WORD;
         mem_wdata_out <= RST_ACC;
         mem_rd_out    <= 1'b0;
         mem_wr_out    <= 1'b0;
         ret_addr      <= RST_WORD;
      end else begin
         mem_rd_out <= 1'b0;
         mem_wr_out <= 1'b0;
         if (take) begin
            case (take_class)
               CL_MEM_INC: begin
                  mem_addr_out <= eff_addr_in;
                  mem_rd_out   <= 1'b1;
               end
               CL_CALL: begin
                  // high byte goes out first, at the lower address
                  ret_addr      <= next_pc_in;
                  mem_addr_out  <= stack_dec;
                  mem_wdata_out <= next_pc_in[15:8];
                  mem_wr_out    <= 1'b1;
               end
               default: ;
            endcase
         end else if (state == ST_MEM_WRITE) begin
            // same address kept; exactly one write per increment
            mem_wdata_out <= inc8_mem[7:0];
            mem_wr_out    <= 1'b1;
         end else if (state == ST_PUSH_LO) begin
            mem_addr_out  <= mem_addr_out + WORD_ONE;
            mem_wdata_out <= ret_addr[7:0];
            mem_wr_out    <= 1'b1;
         end
      end
   end

   // ==========================================================
   // programmer-visible registers; port writes refused while busy
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         acc_a           <= RST_ACC;
         acc_b           <= RST_ACC;
         index_x         <= RST_WORD;
         index_y         <= RST_WORD;
         stack_pointer   <= RST_WORD;
         prog_counter    <= RST_WORD;
         condition_flags <= RST_FLAGS;
      end else if (take) begin
         case (opcode_in)
            OP_INC_A: begin
               acc_a           <= inc8_a[7:0];
               condition_flags <= put_nzv(condition_flags, inc8_a);
            end
            OP_INC_B: begin
               acc_b           <= inc8_b[7:0];
               condition_flags <= put_nzv(condition_flags, inc8_b);
            end
            OP_INC_X: begin
               index_x         <= next_x;
               condition_flags <= put_z16(condition_flags, next_x);
            end
            OP_INC_Y: begin
               index_y         <= next_y;
               condition_flags <= put_z16(condition_flags, next_y);
            end
            OP_LEA_STACK: begin
               // flags untouched on purpose
               if (postbyte_in == PB_STACK_P1) begin
                  stack_pointer <= next_sp;
               end
            end
            OP_JMP_EXT, OP_JMP_IDX: begin
               prog_counter <= eff_addr_in;
            end
            OP_CALL_DIR, OP_CALL_EXT, OP_CALL_IDX: begin
               stack_pointer <= stack_dec;
               prog_counter  <= eff_addr_in;
            end
            default: ;
         endcase
      end else if (state == ST_MEM_WRITE) begin
         // carry kept; no register besides the flags moves
         condition_flags <= put_nzv(condition_flags, inc8_mem);
      end else if (reg_wr_in && state == ST_IDLE) begin
         // dropped silently while busy; poll the status word first
         case (reg_addr_in)
            REG_ACC_A: acc_a           <= reg_wdata_in[7:0];
            REG_ACC_B: acc_b           <= reg_wdata_in[7:0];
            REG_IDX_X: index_x         <= reg_wdata_in;
            REG_IDX_Y: index_y         <= reg_wdata_in;
            REG_STACK: stack_pointer   <= reg_wdata_in;
            REG_PC:    prog_counter    <= reg_wdata_in;
            REG_FLAGS: condition_flags <= reg_wdata_in[7:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // register read port, data one cycle after the strobe
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         reg_rdata_out <= RST_WORD;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            REG_ACC_A:  reg_rdata_out <= {8'h00, acc_a};
            REG_ACC_B:  reg_rdata_out <= {8'h00, acc_b};
            REG_IDX_X:  reg_rdata_out <= index_x;
            REG_IDX_Y:  reg_rdata_out <= index_y;
            REG_STACK:  reg_rdata_out <= stack_pointer;
            REG_PC:     reg_rdata_out <= prog_counter;
            REG_FLAGS:  reg_rdata_out <= {8'h00, condition_flags};
            REG_STATUS: reg_rdata_out <= {15'h0000, busy_out};
            default:    reg_rdata_out <= RST_WORD;
         endcase
      end else begin
         reg_rdata_out <= RST_WORD;
      end
   end

endmodule

// ===== hdl/ijc_pkg.sv
// ijc_pkg: constants for the increment, jump and call execution block.
// assumes: shared by the execution core and its verification bench.
package ijc_pkg;

   // ==========================================================
   // opcodes
   localparam logic [7:0] OP_INC_EXT   = 8'h72;
   localparam logic [7:0] OP_INC_IDX   = 8'h62;
   localparam logic [7:0] OP_INC_A     = 8'h42;
   localparam logic [7:0] OP_INC_B     = 8'h52;
   localparam logic [7:0] OP_LEA_STACK = 8'h1B;
   localparam logic [7:0] PB_STACK_P1  = 8'h81;
   localparam logic [7:0] OP_INC_X     = 8'h08;
   localparam logic [7:0] OP_INC_Y     = 8'h02;
   localparam logic [7:0] OP_JMP_EXT   = 8'h06;
   localparam logic [7:0] OP_JMP_IDX   = 8'h05;
   localparam logic [7:0] OP_CALL_DIR  = 8'h17;
   localparam logic [7:0] OP_CALL_EXT  = 8'h16;
   localparam logic [7:0] OP_CALL_IDX  = 8'h15;

   // ==========================================================
   // arithmetic constants
   localparam logic [7:0]  BYTE_ONE    = 8'h01;
   localparam logic [7:0]  BYTE_MAXPOS = 8'h7F;
   localparam logic [7:0]  BYTE_ZERO   = 8'h00;
   localparam logic [15:0] WORD_ONE    = 16'h0001;
   localparam logic [15:0] WORD_TWO    = 16'h0002;
   localparam logic [15:0] WORD_ZERO   = 16'h0000;

   // ==========================================================
   // condition_flags bit positions (S X H I N Z V C)
   localparam int FLAG_N = 3;
   localparam int FLAG_Z = 2;
   localparam int FLAG_V = 1;
   localparam int FLAG_C = 0;

   // ==========================================================
   // register port offsets
   localparam logic [3:0] REG_ACC_A  = 4'h0;
   localparam logic [3:0] REG_ACC_B  = 4'h1;
   localparam logic [3:0] REG_IDX_X  = 4'h2;
   localparam logic [3:0] REG_IDX_Y  = 4'h3;
   localparam logic [3:0] REG_STACK  = 4'h4;
   localparam logic [3:0] REG_PC     = 4'h5;
   localparam logic [3:0] REG_FLAGS  = 4'h6;
   localparam logic [3:0] REG_STATUS = 4'h7;

   // ==========================================================
   // reset values
   localparam logic [7:0]  RST_ACC   = 8'h00;
   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [7:0]  RST_FLAGS = 8'hD0;

endpackage

// ===== verification/ijc_exec_properties.sv
// checker: execute and memory strobe timing at the core's ports
// assumes: bound onto ijc_exec, one clock, synchronous reset
`timescale 1ns/1ps
module ijc_exec_properties
   import ijc_pkg::*;
(
   input wire logic        mclk_in,
   input wire logic        rst_in,
   input wire logic        exec_start_in,
   input wire logic [7:0]  opcode_in,
   input wire logic [7:0]  postbyte_in,
   input wire logic [15:0] eff_addr_in,
   input wire logic        busy_out,
   input wire logic        exec_done_out,
   input wire logic        illegal_out,
   input wire logic        mem_rd_out,
   input wire logic        mem_wr_out,
   input wire logic [15:0] mem_addr_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   // =====
   // taken requests
   wire go      = exec_start_in && !busy_out;
   wire inc_go  = go && opcode_in inside {OP_INC_EXT, OP_INC_IDX};
   wire call_go = go && opcode_in inside {OP_CALL_DIR, OP_CALL_EXT,
                                          OP_CALL_IDX};
   wire one_go  = go && opcode_in inside {OP_INC_A, OP_INC_B, OP_INC_X,
                                          OP_INC_Y, OP_JMP_EXT, OP_JMP_IDX};
   wire lea_go  = go && opcode_in == OP_LEA_STACK &&
                  postbyte_in == PB_STACK_P1;
   sequence rd_then_wr;
      ##1 mem_rd_out && mem_addr_out == $past(eff_addr_in)
      ##2 mem_wr_out && mem_addr_out == $past(mem_addr_out, 2);
   endsequence
   sequence push_two;
      ##1 mem_wr_out
      ##1 mem_wr_out && mem_addr_out == $past(mem_addr_out) + 16'h0001;
   endsequence
   a_inc_read_write: assert property (inc_go |-> rd_then_wr)
      else $error("increment read or write-back misplaced");
   a_inc_one_write: assert property (inc_go |->
      ##1 (!mem_wr_out)[*2] ##1 mem_wr_out ##1 !mem_wr_out)
      else $error("increment write count wrong");
   a_inc_done_time: assert property (inc_go |=>
      busy_out[*3] ##1 (exec_done_out && !busy_out))
      else $error("increment completion late");
   a_call_push: assert property (call_go |-> push_two)
      else $error("return address push wrong");
   a_call_done: assert property (call_go |=>
      busy_out[*2] ##1 (exec_done_out && !mem_rd_out))
      else $error("call completion late");
   a_single_done: assert property (one_go |=>
      exec_done_out && !mem_wr_out && !illegal_out)
      else $error("single cycle operation wrong");
   a_stack_bump: assert property (lea_go |=>
      exec_done_out && !illegal_out && !mem_wr_out)
      else $error("stack increment refused");
   a_illegal_done: assert property (illegal_out |-> exec_done_out)
      else $error("illegal pulse without completion");
endmodule

bind ijc_exec ijc_exec_properties u_ijc_exec_properties (
   .mclk_in, .rst_in, .exec_start_in, .opcode_in, .postbyte_in,
   .eff_addr_in, .busy_out, .exec_done_out, .illegal_out,
   .mem_rd_out, .mem_wr_out, .mem_addr_out
);

// ===== verification/ijc_mem_model.sv
// partner: byte memory on the core's system bus
// assumes: one clock, reads answered next cycle, never waits
`timescale 1ns/1ps
module ijc_mem_model (
   input  wire logic        mclk_in,
   input  wire logic [15:0] mem_addr_in,
   input  wire logic [7:0]  mem_wdata_in,
   input  wire logic        mem_rd_in,
   input  wire logic        mem_wr_in,
   output logic [7:0]       mem_rdata_out
);
   logic [7:0] mem [0:65535];
   logic [7:0] last     = 8'h00;
   logic       valid    = 1'b0;
   int         wr_count = 0;
   // inverted outside the answer cycle so stale data never passes
   assign mem_rdata_out = valid ? last : ~last;
   always @(posedge mclk_in) begin
      valid <= mem_rd_in;
      if (mem_rd_in)
         last <= mem[mem_addr_in];
      if (mem_wr_in) begin
         mem[mem_addr_in] <= mem_wdata_in;
         wr_count         <= wr_count + 1;
      end
   end
endmodule

// ===== verification/ijc_exec_test.sv
// testbench: random operands through every opcode against a model
// assumes: ijc_mem_model as memory, register port for state access
`timescale 1ns/1ps
module ijc_exec_test;
   import ijc_pkg::*;
   logic        mclk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        exec_start_in = 1'b0;
   logic [7:0]  opcode_in = 8'h00;
   logic [7:0]  postbyte_in = 8'h00;
   logic [15:0] eff_addr_in = 16'h0000;
   logic [15:0] next_pc_in = 16'h0000;
   logic [3:0]  reg_addr_in = 4'h0;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic        reg_wr_in = 1'b0;
   logic        reg_rd_in = 1'b0;
   logic        exec_done_out, illegal_out, busy_out, mem_rd_out, mem_wr_out;
   logic [15:0] mem_addr_out, reg_rdata_out;
   logic [7:0]  mem_wdata_out, mem_rdata_in;
   int          failures = 0;
   int          checks = 0;
   int          cycles = 0;
   int          rg [0:7];
   logic [7:0]  ops [0:13] = '{OP_INC_A, OP_INC_B, OP_INC_X, OP_INC_Y,
      OP_LEA_STACK, OP_LEA_STACK, OP_JMP_EXT, OP_JMP_IDX, OP_INC_EXT,
      OP_INC_IDX, OP_CALL_DIR, OP_CALL_EXT, OP_CALL_IDX, 8'hA7};

   ijc_exec u_ijc_exec (.mclk_in, .rst_in, .exec_start_in, .opcode_in,
      .postbyte_in, .eff_addr_in, .next_pc_in, .exec_done_out, .illegal_out,
      .busy_out, .mem_addr_out, .mem_wdata_out, .mem_rd_out, .mem_wr_out,
      .mem_rdata_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
      .reg_rdata_out);
   ijc_mem_model u_ijc_mem_model (.mclk_in, .mem_addr_in(mem_addr_out),
      .mem_wdata_in(mem_wdata_out), .mem_rd_in(mem_rd_out),
      .mem_wr_in(mem_wr_out), .mem_rdata_out(mem_rdata_in));

   always #2 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         results();
      end
   end
   // =====
   // helpers
   task automatic results();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge mclk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic chk_all();
      for (int a = 0; a < 9; a++) begin
         @(posedge mclk_in);
         reg_rd_in <= 1'b1;
         reg_addr_in <= (a == 8) ? 4'hF : 4'(a);
         @(posedge mclk_in);
         reg_rd_in <= 1'b0;
         #1 chk($sformatf("reg %0d", a), (a == 8) ? 16'h0000 : 16'(rg[a]),
                reg_rdata_out);
      end
   endtask
   task automatic run_op(input logic [7:0] op, pb,
                         input logic [15:0] ea, np, output int n);
      n = 0;
      @(posedge mclk_in);
      exec_start_in <= 1'b1;
      opcode_in <= op;
      postbyte_in <= pb;
      eff_addr_in <= ea;
      next_pc_in <= np;
      do begin
         @(posedge mclk_in);
         exec_start_in <= 1'b0;
         n++;
         #1;
      end while (exec_done_out !== 1'b1 && n < 8);
   endtask
   function automatic int inc8(input int v);
      int r = (v + 1) & 8'hFF;
      rg[6] = (rg[6] & 8'hF1) | ((r >> 7) << FLAG_N) |
              (int'(r == 0) << FLAG_Z) | (int'(v == BYTE_MAXPOS) << FLAG_V);
      return r;
   endfunction
   function automatic int pick();
      int r = $urandom % 4;
      return (r == 0) ? 16'h007F : (r == 1) ? 16'hFFFF : $urandom;
   endfunction
   // =====
   // sequence
   initial begin
      int i, k, ea, mv, np, w0, ill, wn, lat, em, n;
      logic [7:0] op, pb;
      k = $urandom(32'hBB9E);
      foreach (rg[j]) rg[j] = 0;
      rg[6] = RST_FLAGS;
      repeat (10) @(posedge mclk_in);
      rst_in <= 1'b0;
      chk_all();
      $display("test reset done");
      for (i = 0; i < 42; i++) begin
         op = ops[i % 14];
         pb = (i % 14 == 5) ? 8'h83 : PB_STACK_P1;
         for (k = 0; k < 7; k++) begin
            rg[k] = pick() & ((k < 2 || k == 6) ? 16'h00FF : 16'hFFFF);
            reg_wr(4'(k), 16'(rg[k]));
         end
         ea = $urandom & 16'hFFFF;
         mv = pick() & 8'hFF;
         np = $urandom & 16'hFFFF;
         u_ijc_mem_model.mem[ea] = 8'(mv);
         w0 = u_ijc_mem_model.wr_count;
         ill = 0;
         wn = 0;
         lat = 1;
         em = mv;
         case (op)
            OP_INC_A: rg[0] = inc8(rg[0]);
            OP_INC_B: rg[1] = inc8(rg[1]);
            OP_INC_X, OP_INC_Y: begin
               k = (op == OP_INC_X) ? 2 : 3;
               rg[k] = (rg[k] + 1) & 16'hFFFF;
               rg[6] = (rg[6] & 8'hFB) |
                       (int'(rg[k] == 0) << FLAG_Z);
            end
            OP_LEA_STACK: begin
               if (pb == PB_STACK_P1)
                  rg[4] = (rg[4] + 1) & 16'hFFFF;
               else
                  ill = 1;
            end
            OP_JMP_EXT, OP_JMP_IDX: rg[5] = ea;
            OP_INC_EXT, OP_INC_IDX: begin
               em = inc8(mv);
               wn = 1;
               lat = 4;
            end
            OP_CALL_DIR, OP_CALL_EXT, OP_CALL_IDX: begin
               rg[4] = (rg[4] - 2) & 16'hFFFF;
               rg[5] = ea;
               wn = 2;
               lat = 3;
            end
            default: ill = 1;
         endcase
         run_op(op, pb, 16'(ea), 16'(np), n);
         chk("latency", 16'(lat), 16'(n));
         chk("illegal", 16'(ill), {15'h0000, illegal_out});
         chk("writes", 16'(wn), 16'(u_ijc_mem_model.wr_count - w0));
         if (wn == 1)
            chk("mem", 16'(em), {8'h00, u_ijc_mem_model.mem[ea]});
         if (wn == 2) begin
            chk("ret_hi", 16'(np >> 8),
                {8'h00, u_ijc_mem_model.mem[rg[4]]});
            chk("ret_lo", 16'(np & 8'hFF),
                {8'h00, u_ijc_mem_model.mem[(rg[4] + 1) & 16'hFFFF]});
         end
         chk_all();
         $display("test %0d opcode %h done", i, op);
      end
      results();
   end
endmodule
